/* File: logic/cipi_pkg.sv */
// Shared constants and types for the current input process image ends
package cipi_pkg;
   localparam int NCH = 4;
   localparam int CODE_W = 12;
   localparam int WORD_W = 16;
   localparam int CLK_MHZ = 20;
   localparam int CONV_TIME_US = 80000;
   localparam int XFER_TIME_US = 6500;
   localparam int HART_TIME_US = 50000;
   localparam int CONV_CYC = CONV_TIME_US * CLK_MHZ;
   localparam int XFER_CYC = XFER_TIME_US * CLK_MHZ;
   localparam int HART_CYC = HART_TIME_US * CLK_MHZ;
   // One code step is 0.04 % of the 4..20 mA span, 6.4 uA
   localparam int CODE_4MA = 625;
   localparam int SPAN_STEPS = 2500;
   localparam int STEPS_PER_PCT = 25;
   localparam int RATE_GAIN = STEPS_PER_PCT * CONV_TIME_US / 1000000;
   localparam int PCT_MIN = -625;
   localparam int PCT_MAX = 3125;
   localparam logic [11:0] LIVE_ZERO_CODE = 12'h233;
   localparam logic [15:0] BRK_RESET = 16'h009D;
   localparam logic [15:0] SHORT_RESET = 16'h0CD1;
   localparam logic [15:0] SCALE_LO_RESET = 16'h2710;
   localparam logic [15:0] SCALE_HI_RESET = 16'hC350;
   localparam logic [15:0] SCALE_WIN_LO = 16'h2710;
   localparam logic [15:0] SCALE_WIN_HI = 16'hC350;
   localparam logic [15:0] WORD_MAX = 16'hFFFF;
   // Local configuration port: address = {channel, index}
   localparam int CFG_AW = 5;
   localparam logic [2:0] REG_CFG = 3'h0;
   localparam logic [2:0] REG_RATE = 3'h1;
   localparam logic [2:0] REG_SIM = 3'h2;
   localparam logic [2:0] REG_SUBST = 3'h3;
   localparam logic [2:0] REG_SCALE_LO = 3'h4;
   localparam logic [2:0] REG_SCALE_HI = 3'h5;
   localparam logic [2:0] REG_BRK = 3'h6;
   localparam logic [2:0] REG_SHORT = 3'h7;
   localparam int CFG_SIM_BIT = 0;
   localparam int CFG_SIMINV_BIT = 1;
   localparam int CFG_STRAT_LSB = 2;
   localparam int CFG_LFEN_BIT = 4;
   localparam int CFG_HART_BIT = 5;
   localparam int CFG_FAULT_BIT = 8;
   localparam int CFG_LZ_BIT = 9;
   localparam int CFG_INV_BIT = 10;
   localparam logic [1:0] STRAT_CURRENT = 2'h0;
   localparam logic [1:0] STRAT_SUBST = 2'h1;
   localparam logic [1:0] STRAT_LAST = 2'h2;
   // MODBUS side, direct numbering
   localparam logic [7:0] FC_READ_STATUS = 8'h02;
   localparam logic [7:0] FC_READ_HOLDING = 8'h03;
   localparam logic [7:0] FC_READ_INPUT = 8'h04;
   localparam logic [15:0] BASE_ALLOC_IN = 16'h0000;
   localparam logic [15:0] BASE_SLOT_IN = 16'h0200;
   localparam logic [15:0] BASE_STATUS = 16'h0300;
   localparam logic [15:0] BASE_TYPE = 16'h0400;
   localparam logic [15:0] BASE_HOLDING = 16'h0600;
   localparam logic [15:0] BASE_STATUS_BITS = 16'h0800;
   localparam int SLOT_WORDS = 2;
   localparam int SLOT_BITS = 8;
   localparam int STATUS_HI_LSB = 8;
   typedef enum logic [2:0] {
      CIPI_KIND_ALLOC = 3'h0,
      CIPI_KIND_SLOT = 3'h1,
      CIPI_KIND_STATUS = 3'h2,
      CIPI_KIND_TYPE = 3'h3,
      CIPI_KIND_HOLD = 3'h4,
      CIPI_KIND_SBIT = 3'h5
   } cipi_kind_t;
endpackage

/* File: logic/cipi_if.sv */
// Register read link between the MODBUS master and the channel image
`timescale 1ns/100ps
interface cipi_if;
   logic req;          // One-cycle read request
   logic [7:0] fcode;  // MODBUS function code
   logic [15:0] addr;  // Register or bit address, direct numbering
   logic rvalid;       // Answer strobe, cycle after req
   logic [15:0] rdata; // Answer data
   logic exc;          // Address or function not served
   modport dev (input req, input fcode, input addr, output rvalid, output rdata, output exc);
   modport host (output req, output fcode, output addr, input rvalid, input rdata, input exc);
endinterface

/* File: logic/cipi_dev.sv */
// Current input channel processing and MODBUS image, device end
// Overview of operation
// - Rate filter in percent per second, zero disables
// - Simulation mode reports clamped simulation value
// - Simulation invalid option marks value invalid
// - Substitute strategy on error reports substitute value
// - Substitute value is always invalid
// - Twelve-bit codes cover zero to 26.2 mA
// - 4..20 mA is 2500 steps, overrange kept
// - One conversion pass every 80 ms
// - Image sent to com unit every 6.5 ms
// - With HART, fresh values every 50 ms
// - Process value is unsigned 16 bits
// - Low four word bits carry status
// - Scaling outside 10000..50000 drops status bits
// - Bit 0 flags current below 3.6 mA
// - Bit 1 flags line fault
// - Bits 2,3 empty, value from bit 4
// - Four identical channel words, no outputs
// - Input registers: allocated or slot-based area
// - Status high byte as discrete input bits
// - Status and type words at base plus slot
// - Allocated data also as holding registers
// - Line fault on break or short thresholds
// - Error strategy: current, substitute, last valid
`timescale 1ns/100ps
module cipi_dev #(
   parameter int SLOT = 0,                          // Backplane slot of the module
   parameter logic [15:0] TYPE_CODE = 16'h00A5,     // Arbitrary module type value
   parameter int CONV_CYCLES = cipi_pkg::CONV_CYC,  // Conversion pass period
   parameter int XFER_CYCLES = cipi_pkg::XFER_CYC,  // Com unit update period
   parameter int HART_CYCLES = cipi_pkg::HART_CYC   // Update period under HART
) (
   input wire logic clock,                                  // 20 MHz clock
   input wire logic rst_n,                                  // Asynchronous reset, active low
   cipi_if.dev link,                                        // MODBUS read side
   output logic conv_start,                                 // Starts a conversion pass
   input wire logic adc_done,                               // Pass results valid
   input wire logic [cipi_pkg::NCH-1:0][11:0] adc_code,     // Codes, 6.4 uA per step
   input wire logic [cipi_pkg::CFG_AW-1:0] cfg_addr,        // Config address
   input wire logic [15:0] cfg_wdata,                       // Config write data
   input wire logic cfg_wr,                                 // Config write strobe
   input wire logic cfg_rd,                                 // Config read strobe
   output logic [15:0] cfg_rdata,                           // Config read data, next cycle
   output logic xfer_tick                                   // Image refreshed this cycle
);
   localparam int N = cipi_pkg::NCH;

   typedef struct packed {
      logic [N-1:0][15:0] cfg;
      logic [N-1:0][15:0] rate;
      logic [N-1:0][15:0] sim;
      logic [N-1:0][15:0] subst;
      logic [N-1:0][15:0] slo;
      logic [N-1:0][15:0] shi;
      logic [N-1:0][15:0] brk;
      logic [N-1:0][15:0] shrt;
      logic [N-1:0][11:0] filt;
      logic [N-1:0][11:0] last;
      logic [N-1:0][15:0] live;
      logic [N-1:0][15:0] img;
      logic [N-1:0] fault;
      logic [N-1:0] lz;
      logic [N-1:0] inv;
      logic [N-1:0] img_fault;
      logic [N-1:0] img_inv;
      logic [31:0] conv_cnt;
      logic [31:0] xfer_cnt;
      logic conv_start;
      logic xfer_tick;
      logic [15:0] cfg_rdata;
      logic rvalid;
      logic exc;
      logic [15:0] rdata;
   } cipi_dev_state_t;

   cipi_dev_state_t state_reg;
   cipi_dev_state_t state_next;

   // Percent value in 0.04 % steps, limited to -25..125 %, as a code
   function automatic logic [11:0] cipi_pct_code(input logic [15:0] pct);
      logic signed [31:0] p;
      p = 32'(signed'(pct));
      if (p < cipi_pkg::PCT_MIN) begin
         p = cipi_pkg::PCT_MIN;
      end
      if (p > cipi_pkg::PCT_MAX) begin
         p = cipi_pkg::PCT_MAX;
      end
      return 12'(p + cipi_pkg::CODE_4MA);
   endfunction

   // Maps 4 mA to lo and 20 mA to hi, saturating at 0 and 65535
   function automatic logic [15:0] cipi_scale(input logic [11:0] code, input logic [15:0] lo, input logic [15:0] hi);
      logic signed [31:0] p;
      p = (signed'({20'h0_0000, code}) - cipi_pkg::CODE_4MA) * (signed'({16'h0000, hi}) - signed'({16'h0000, lo}));
      p = p / cipi_pkg::SPAN_STEPS + signed'({16'h0000, lo});
      if (p < 0) begin
         p = 0;
      end
      if (p > signed'({16'h0000, cipi_pkg::WORD_MAX})) begin
         p = signed'({16'h0000, cipi_pkg::WORD_MAX});
      end
      return p[15:0];
   endfunction

   always_comb begin
      logic signed [31:0] diff;
      logic signed [31:0] lim;
      logic [11:0] code;
      logic [11:0] val;
      logic [15:0] sc;
      logic err;
      logic vinv;
      logic hart;
      logic [15:0] status;
      logic [15:0] a;
      logic [1:0] ch;
      logic [2:0] idx;
      diff = 0;
      lim = 0;
      code = '0;
      val = '0;
      sc = '0;
      err = 1'b0;
      vinv = 1'b0;
      hart = 1'b0;
      status = '0;
      a = link.addr;
      ch = cfg_addr[4:3];
      idx = cfg_addr[2:0];
      state_next = state_reg;
      state_next.conv_start = 1'b0;
      state_next.xfer_tick = 1'b0;
      state_next.rvalid = 1'b0;
      state_next.exc = 1'b0;

      // Pass timer
      if (state_reg.conv_cnt == 32'(CONV_CYCLES - 1)) begin
         state_next.conv_cnt = '0;
         state_next.conv_start = 1'b1;
      end else begin
         state_next.conv_cnt = state_reg.conv_cnt + 32'h0000_0001;
      end

      // Channel processing on each finished pass
      for (int i = 0; i < N; i++) begin
         hart = hart | state_reg.cfg[i][cipi_pkg::CFG_HART_BIT];
         if (adc_done) begin
            code = adc_code[i];
            err = state_reg.cfg[i][cipi_pkg::CFG_LFEN_BIT] &&
                  ((16'(code) < state_reg.brk[i]) || (16'(code) > state_reg.shrt[i]));
            state_next.fault[i] = err;
            state_next.lz[i] = code < cipi_pkg::LIVE_ZERO_CODE;
            diff = signed'({20'h0_0000, code}) - signed'({20'h0_0000, state_reg.filt[i]});
            lim = signed'({16'h0000, state_reg.rate[i]}) * cipi_pkg::RATE_GAIN;
            if (state_reg.rate[i] == 16'h0000 || (diff <= lim && diff >= -lim)) begin
               state_next.filt[i] = code;
            end else if (diff > 0) begin
               state_next.filt[i] = 12'(signed'({20'h0_0000, state_reg.filt[i]}) + lim);
            end else begin
               state_next.filt[i] = 12'(signed'({20'h0_0000, state_reg.filt[i]}) - lim);
            end
            val = state_next.filt[i];
            vinv = 1'b0;
            if (state_reg.cfg[i][cipi_pkg::CFG_SIM_BIT]) begin
               val = cipi_pct_code(state_reg.sim[i]);
               vinv = state_reg.cfg[i][cipi_pkg::CFG_SIMINV_BIT];
            end else if (err) begin
               case (state_reg.cfg[i][cipi_pkg::CFG_STRAT_LSB +: 2])
                  cipi_pkg::STRAT_SUBST: begin
                     val = cipi_pct_code(state_reg.subst[i]);
                     vinv = 1'b1;
                  end
                  cipi_pkg::STRAT_LAST: begin
                     val = state_reg.last[i];
                  end
                  default: begin
                     val = state_next.filt[i];
                  end
               endcase
            end else begin
               state_next.last[i] = state_next.filt[i];
            end
            state_next.inv[i] = vinv;
            sc = cipi_scale(val, state_reg.slo[i], state_reg.shi[i]);
            if (state_reg.slo[i] >= cipi_pkg::SCALE_WIN_LO && state_reg.shi[i] <= cipi_pkg::SCALE_WIN_HI) begin
               state_next.live[i] = {sc[15:4], 2'b00, err, state_next.lz[i]};
            end else begin
               state_next.live[i] = sc;
            end
         end
      end

      // Com unit update, slower while any channel runs HART
      if (state_reg.xfer_cnt >= 32'((hart ? HART_CYCLES : XFER_CYCLES) - 1)) begin
         state_next.xfer_cnt = '0;
         state_next.xfer_tick = 1'b1;
         state_next.img = state_reg.live;
         state_next.img_fault = state_reg.fault;
         state_next.img_inv = state_reg.inv;
      end else begin
         state_next.xfer_cnt = state_reg.xfer_cnt + 32'h0000_0001;
      end

      // Configuration port
      if (cfg_wr) begin
         case (idx)
            cipi_pkg::REG_CFG: state_next.cfg[ch] = cfg_wdata;
            cipi_pkg::REG_RATE: state_next.rate[ch] = cfg_wdata;
            cipi_pkg::REG_SIM: state_next.sim[ch] = cfg_wdata;
            cipi_pkg::REG_SUBST: state_next.subst[ch] = cfg_wdata;
            cipi_pkg::REG_SCALE_LO: state_next.slo[ch] = cfg_wdata;
            cipi_pkg::REG_SCALE_HI: state_next.shi[ch] = cfg_wdata;
            cipi_pkg::REG_BRK: state_next.brk[ch] = cfg_wdata;
            default: state_next.shrt[ch] = cfg_wdata;
         endcase
      end
      if (cfg_rd) begin
         case (idx)
            cipi_pkg::REG_CFG: begin
               state_next.cfg_rdata = {5'h00, state_reg.inv[ch], state_reg.lz[ch], state_reg.fault[ch],
                                       state_reg.cfg[ch][7:0]};
            end
            cipi_pkg::REG_RATE: state_next.cfg_rdata = state_reg.rate[ch];
            cipi_pkg::REG_SIM: state_next.cfg_rdata = state_reg.sim[ch];
            cipi_pkg::REG_SUBST: state_next.cfg_rdata = state_reg.subst[ch];
            cipi_pkg::REG_SCALE_LO: state_next.cfg_rdata = state_reg.slo[ch];
            cipi_pkg::REG_SCALE_HI: state_next.cfg_rdata = state_reg.shi[ch];
            cipi_pkg::REG_BRK: state_next.cfg_rdata = state_reg.brk[ch];
            default: state_next.cfg_rdata = state_reg.shrt[ch];
         endcase
      end

      // MODBUS reads serve only the transferred image
      status = {4'h0, state_reg.img_fault, 4'h0, state_reg.img_inv};
      if (link.req) begin
         state_next.rvalid = 1'b1;
         state_next.rdata = '0;
         state_next.exc = 1'b1;
         if (link.fcode == cipi_pkg::FC_READ_INPUT) begin
            if (a < 16'(cipi_pkg::BASE_ALLOC_IN + N)) begin
               state_next.rdata = state_reg.img[a[1:0]];
               state_next.exc = 1'b0;
            end else if (a >= 16'(cipi_pkg::BASE_SLOT_IN + cipi_pkg::SLOT_WORDS * SLOT) &&
                         a < 16'(cipi_pkg::BASE_SLOT_IN + cipi_pkg::SLOT_WORDS * SLOT + N)) begin
               state_next.rdata = state_reg.img[2'(a - 16'(cipi_pkg::BASE_SLOT_IN + cipi_pkg::SLOT_WORDS * SLOT))];
               state_next.exc = 1'b0;
            end else if (a == 16'(cipi_pkg::BASE_STATUS + SLOT)) begin
               state_next.rdata = status;
               state_next.exc = 1'b0;
            end else if (a == 16'(cipi_pkg::BASE_TYPE + SLOT)) begin
               state_next.rdata = TYPE_CODE;
               state_next.exc = 1'b0;
            end
         end else if (link.fcode == cipi_pkg::FC_READ_HOLDING) begin
            if (a >= cipi_pkg::BASE_HOLDING && a < 16'(cipi_pkg::BASE_HOLDING + N)) begin
               state_next.rdata = state_reg.img[a[1:0]];
               state_next.exc = 1'b0;
            end
         end else if (link.fcode == cipi_pkg::FC_READ_STATUS) begin
            if (a >= 16'(cipi_pkg::BASE_STATUS_BITS + cipi_pkg::SLOT_BITS * SLOT) &&
                a < 16'(cipi_pkg::BASE_STATUS_BITS + cipi_pkg::SLOT_BITS * SLOT + cipi_pkg::SLOT_BITS)) begin
               state_next.rdata = {15'h0000, status[cipi_pkg::STATUS_HI_LSB + 32'(a[2:0])]};
               state_next.exc = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= '0;
         state_reg.slo <= {N{cipi_pkg::SCALE_LO_RESET}};
         state_reg.shi <= {N{cipi_pkg::SCALE_HI_RESET}};
         state_reg.brk <= {N{cipi_pkg::BRK_RESET}};
         state_reg.shrt <= {N{cipi_pkg::SHORT_RESET}};
      end else begin
         state_reg <= state_next;
      end
   end

   assign conv_start = state_reg.conv_start;
   assign xfer_tick = state_reg.xfer_tick;
   assign cfg_rdata = state_reg.cfg_rdata;
   assign link.rvalid = state_reg.rvalid;
   assign link.rdata = state_reg.rdata;
   assign link.exc = state_reg.exc;
endmodule // cipi_dev

/* File: logic/cipi_host.sv */
// MODBUS master end: forms area addresses and reads the channel image
`timescale 1ns/100ps
module cipi_host #(
   parameter int SLOT = 0  // Slot of the module being read
) (
   input wire logic clock,                   // 20 MHz clock
   input wire logic rst_n,                   // Asynchronous reset, active low
   cipi_if.host link,                        // MODBUS read side
   input wire logic cmd_valid,               // Read command
   input wire cipi_pkg::cipi_kind_t cmd_kind, // Area to read
   input wire logic [7:0] cmd_index,         // Channel or bit number
   output logic cmd_ready,                   // Command may be taken
   output logic rsp_valid,                   // Answer strobe
   output logic [15:0] rsp_data,             // Answer data
   output logic rsp_exc                      // Device refused the address
);
   typedef enum logic [0:0] {
      CIPI_H_IDLE = 1'b0,
      CIPI_H_WAIT = 1'b1
   } cipi_hstate_t;

   typedef struct packed {
      cipi_hstate_t st;
      logic req;
      logic [7:0] fcode;
      logic [15:0] addr;
      logic rsp_valid;
      logic [15:0] rsp_data;
      logic rsp_exc;
   } cipi_host_state_t;

   cipi_host_state_t state_reg;
   cipi_host_state_t state_next;

   always_comb begin
      logic [15:0] idx;
      idx = {8'h00, cmd_index};
      state_next = state_reg;
      state_next.req = 1'b0;
      state_next.rsp_valid = 1'b0;
      case (state_reg.st)
         CIPI_H_IDLE: begin
            if (cmd_valid) begin
               state_next.req = 1'b1;
               state_next.st = CIPI_H_WAIT;
               state_next.fcode = cipi_pkg::FC_READ_INPUT;
               case (cmd_kind)
                  cipi_pkg::CIPI_KIND_ALLOC: state_next.addr = cipi_pkg::BASE_ALLOC_IN + idx;
                  cipi_pkg::CIPI_KIND_SLOT: begin
                     state_next.addr = 16'(cipi_pkg::BASE_SLOT_IN + cipi_pkg::SLOT_WORDS * SLOT) + idx;
                  end
                  cipi_pkg::CIPI_KIND_STATUS: state_next.addr = 16'(cipi_pkg::BASE_STATUS + SLOT);
                  cipi_pkg::CIPI_KIND_TYPE: state_next.addr = 16'(cipi_pkg::BASE_TYPE + SLOT);
                  cipi_pkg::CIPI_KIND_HOLD: begin
                     state_next.fcode = cipi_pkg::FC_READ_HOLDING;
                     state_next.addr = cipi_pkg::BASE_HOLDING + idx;
                  end
                  default: begin
                     state_next.fcode = cipi_pkg::FC_READ_STATUS;
                     state_next.addr = 16'(cipi_pkg::BASE_STATUS_BITS + cipi_pkg::SLOT_BITS * SLOT) + idx;
                  end
               endcase
            end
         end
         CIPI_H_WAIT: begin
            if (link.rvalid) begin
               state_next.st = CIPI_H_IDLE;
               state_next.rsp_valid = 1'b1;
               state_next.rsp_data = link.rdata;
               state_next.rsp_exc = link.exc;
            end
         end
         default: state_next.st = CIPI_H_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign cmd_ready = (state_reg.st == CIPI_H_IDLE);
   assign link.req = state_reg.req;
   assign link.fcode = state_reg.fcode;
   assign link.addr = state_reg.addr;
   assign rsp_valid = state_reg.rsp_valid;
   assign rsp_data = state_reg.rsp_data;
   assign rsp_exc = state_reg.rsp_exc;
endmodule // cipi_host

/* File: tb/cipi_link_assertions.sv */
// Protocol and address map checks on the link between master and device
`timescale 1ns/100ps
module cipi_link_check #(
   parameter int SLOT = 0,                     // Slot being read
   parameter logic [15:0] TYPE_CODE = 16'h00A5 // Type word the device reports
) (
   input wire logic clock,        // Clock
   input wire logic rst_n,        // Reset, active low
   input wire logic req,          // Read request
   input wire logic [7:0] fcode,  // Function code
   input wire logic [15:0] addr,  // Address, direct numbering
   input wire logic rvalid,       // Answer strobe
   input wire logic [15:0] rdata, // Answer data
   input wire logic exc           // Refused
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic rd_in;
   assign rd_in = req && fcode == cipi_pkg::FC_READ_INPUT;
   sequence s_ask;
      req ##1 rvalid;
   endsequence
   answer_time_a: assert property (req |-> s_ask) else $error("answer late");
   no_spurious_a: assert property (!req |=> !rvalid) else $error("answer without request");
   one_outstanding_a: assert property (req |=> !req) else $error("requests back to back");
   refuse_zero_a: assert property (rvalid && exc |-> rdata == 16'h0000) else $error("refusal carries data");
   alloc_area_a: assert property (rd_in && addr < 16'h0004 |=> !exc) else $error("allocated word refused");
   slot_area_a: assert property (rd_in && addr >= cipi_pkg::BASE_SLOT_IN + 2 * SLOT
      && addr < cipi_pkg::BASE_SLOT_IN + 2 * SLOT + 4 |=> !exc) else $error("slot word refused");
   holding_area_a: assert property (req && fcode == cipi_pkg::FC_READ_HOLDING && addr >= cipi_pkg::BASE_HOLDING
      && addr < cipi_pkg::BASE_HOLDING + 4 |=> !exc) else $error("holding word refused");
   status_bit_a: assert property (req && fcode == cipi_pkg::FC_READ_STATUS && addr >= cipi_pkg::BASE_STATUS_BITS + 8 * SLOT
      && addr < cipi_pkg::BASE_STATUS_BITS + 8 * SLOT + 8 |=> !exc && rdata[15:1] == 15'h0000)
      else $error("status bit bad");
   type_word_a: assert property (rd_in && addr == cipi_pkg::BASE_TYPE + SLOT |=> rdata == TYPE_CODE && !exc)
      else $error("type word bad");
   status_word_a: assert property (rd_in && addr == cipi_pkg::BASE_STATUS + SLOT |=> !exc
      && rdata[15:12] == 4'h0 && rdata[7:4] == 4'h0) else $error("status word bad");
endmodule // cipi_link_check

/* File: tb/test_current_input_process_image.sv */
// Self-checking bench joining the device and master ends over the link
`timescale 1ns/100ps
module test_current_input_process_image;
   localparam logic [15:0] TYPE_VAL = 16'h00A5; // Arbitrary type value
   logic clock, rst_n, adc_done, cfg_wr, cfg_rd, cmd_valid, cmd_ready, rsp_valid, rsp_exc, conv_start, xfer_tick, e;
   logic [cipi_pkg::NCH-1:0][11:0] adc_code;
   logic [4:0] cfg_addr;
   logic [15:0] cfg_wdata, cfg_rdata, rsp_data, d;
   logic [7:0] cmd_index;
   cipi_pkg::cipi_kind_t cmd_kind;
   int fails = 0, cmp_count = 0, cyc = 0;
   realtime t0;
   logic [11:0] row_code [4] = '{12'h0271, 12'h0C35, 12'h01F4, 12'h03E8};
   logic [15:0] row_word [4] = '{16'h2710, 16'hC350, 16'h1F41, 16'h3E80};
   cipi_pkg::cipi_kind_t kinds [3] = '{cipi_pkg::CIPI_KIND_ALLOC, cipi_pkg::CIPI_KIND_SLOT, cipi_pkg::CIPI_KIND_HOLD};
   cipi_if lnk ();
   // Short counts keep the run brief; periods below follow from them
   // Type word left at its default, which the bench value matches
   cipi_dev #(.SLOT(1), .CONV_CYCLES(40), .XFER_CYCLES(10), .HART_CYCLES(30)) i_cipi_dev (
      .clock(clock), .rst_n(rst_n), .link(lnk), .conv_start(conv_start), .adc_done(adc_done), .adc_code(adc_code),
      .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata),
      .xfer_tick(xfer_tick));
   cipi_host #(.SLOT(1)) i_cipi_host (.clock(clock), .rst_n(rst_n), .link(lnk), .cmd_valid(cmd_valid),
      .cmd_kind(cmd_kind), .cmd_index(cmd_index), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .rsp_exc(rsp_exc));
   cipi_link_check #(.SLOT(1), .TYPE_CODE(TYPE_VAL)) i_cipi_link_check (.clock(clock), .rst_n(rst_n), .req(lnk.req),
      .fcode(lnk.fcode), .addr(lnk.addr), .rvalid(lnk.rvalid), .rdata(lnk.rdata), .exc(lnk.exc));
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic cfg_w(input logic [1:0] ch, input logic [2:0] idx, input logic [15:0] val);
      @(posedge clock);
      cfg_addr <= {ch, idx};
      cfg_wdata <= val;
      cfg_wr <= 1'b1;
      @(posedge clock);
      cfg_wr <= 1'b0;
   endtask
   task automatic cfg_r(input logic [1:0] ch, input logic [2:0] idx);
      @(posedge clock);
      cfg_addr <= {ch, idx};
      cfg_rd <= 1'b1;
      @(posedge clock);
      cfg_rd <= 1'b0;
      @(negedge clock);
      d = cfg_rdata;
   endtask
   task automatic rd(input cipi_pkg::cipi_kind_t k, input logic [7:0] idx);
      int n;
      @(posedge clock);
      cmd_valid <= 1'b1;
      cmd_kind <= k;
      cmd_index <= idx;
      @(posedge clock);
      cmd_valid <= 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 20) begin
         @(negedge clock);
         n++;
      end
      if (n == 20) fails++;
      d = rsp_data;
      e = rsp_exc;
   endtask
   // Two passes so a config change has surely reached the image
   task automatic settle();
      repeat (2) @(posedge adc_done);
      @(posedge xfer_tick);
      repeat (2) @(posedge clock);
   endtask
   task automatic period(input logic [15:0] exp);
      @(posedge xfer_tick);
      t0 = $realtime;
      @(posedge xfer_tick);
      check("refresh period", 16'(int'(($realtime - t0) / 50.0)), exp);
   endtask
   always #25 clock = ~clock;
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) adc_done <= 1'b0;
      else adc_done <= conv_start;
   end
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         give_verdict();
      end
   end
   initial begin
      clock = 1'b0;
      rst_n = 1'b0;
      adc_code = '0;
      cfg_addr = '0;
      cfg_wdata = '0;
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      cmd_valid = 1'b0;
      cmd_kind = cipi_pkg::CIPI_KIND_ALLOC;
      cmd_index = '0;
      @(negedge clock);
      check("rsp_valid in reset", {15'h0000, rsp_valid}, 16'h0000);
      check("req in reset", {15'h0000, lnk.req}, 16'h0000);
      @(posedge clock);
      rst_n <= 1'b1;
      for (int c = 0; c < 4; c++) adc_code[c] <= row_code[c];
      settle();
      check("ready after reset", {15'h0000, cmd_ready}, 16'h0001);
      period(16'h000A);
      @(posedge conv_start);
      t0 = $realtime;
      @(posedge conv_start);
      check("pass period", 16'(int'(($realtime - t0) / 50.0)), 16'h0028);
      foreach (kinds[k]) begin
         for (int c = 0; c < 4; c++) begin
            rd(kinds[k], 8'(c));
            check("channel word", d, row_word[c]);
            check("channel exc", {15'h0000, e}, 16'h0000);
         end
      end
      rd(cipi_pkg::CIPI_KIND_TYPE, 8'h00);
      check("type word", d, TYPE_VAL);
      rd(cipi_pkg::CIPI_KIND_ALLOC, 8'h04);
      check("unmapped exc", {15'h0000, e}, 16'h0001);
      // Sim above range clamps, substitute below range clamps and needs a real fault
      cfg_w(2'd0, cipi_pkg::REG_SIM, 16'h0FA0);
      cfg_w(2'd0, cipi_pkg::REG_CFG, 16'h0003);
      cfg_w(2'd1, cipi_pkg::REG_SUBST, 16'hFC18);
      cfg_w(2'd1, cipi_pkg::REG_CFG, 16'h0014);
      cfg_w(2'd3, cipi_pkg::REG_SCALE_LO, 16'h0000);
      cfg_w(2'd2, cipi_pkg::REG_RATE, 16'h000A);
      adc_code[1] <= 12'h0064;
      // 10 %/s allows 20 codes per pass, so two passes take 500 only to 540
      adc_code[2] <= 12'h03E8;
      settle();
      rd(cipi_pkg::CIPI_KIND_ALLOC, 8'h02);
      check("damped word", d, 16'h21C0);
      rd(cipi_pkg::CIPI_KIND_ALLOC, 8'h00);
      check("sim word", d, 16'hEA60);
      rd(cipi_pkg::CIPI_KIND_ALLOC, 8'h01);
      check("subst word", d, 16'h0003);
      rd(cipi_pkg::CIPI_KIND_ALLOC, 8'h03);
      check("unscaled word", d, 16'h1D4C);
      rd(cipi_pkg::CIPI_KIND_STATUS, 8'h00);
      check("status word", d, 16'h0203);
      for (int b = 0; b < 8; b++) begin
         rd(cipi_pkg::CIPI_KIND_SBIT, 8'(b));
         check("status bit", d, (b == 1) ? 16'h0001 : 16'h0000);
      end
      cfg_r(2'd1, cipi_pkg::REG_CFG);
      check("channel flags", d, 16'h0714);
      cfg_r(2'd2, cipi_pkg::REG_RATE);
      check("rate readback", d, 16'h000A);
      cfg_w(2'd2, cipi_pkg::REG_CFG, 16'h0020);
      settle();
      period(16'h001E);
      give_verdict();
   end
endmodule // test_current_input_process_image
